/* rtl/spi_pin_consts.svh */
// Constants for the serial peripheral pin block
`ifndef SPI_PIN_CONSTS_SVH
`define SPI_PIN_CONSTS_SVH
// Pin positions inside the four-bit alternate-function vectors
`define PIN_SCLK 0
`define PIN_MOSI 1
`define PIN_MISO 2
`define PIN_SS 3
`define PIN_COUNT 4
// Default word width and receive buffer depth
`define WORD_BITS 8
`define RX_DEPTH 32
// Default serial clock half period in system clocks
`define HALF_DIV 4
// Least half period: two sync stages plus one sample cycle
`define HALF_DIV_MIN 3
// Number of synchroniser stages on every pin input
`define SYNC_STAGES 2
`endif

/* rtl/spi_pin_pkg.sv */
// Types shared by the serial peripheral pin block
package spi_pin_pkg;
   typedef enum logic [1:0] {
      M_IDLE,
      M_RUN
   } m_state_t;
endpackage

/* rtl/spi_pin_interface.sv */
// Serial peripheral pins with master, slave and port E alternate function
// Notes on behaviour
// (RL1) Data-in pin is input as master, output as slave.
// (RL2) Unselected slave releases its data-out pin to high impedance.
// (RL3) Master presents each data bit half a clock before slave samples.
// (RL4) Master drives serial clock out; slave uses that pin as clock.
// (RL5) Select detects other masters as master; selects device as slave.
// (RL6) After reset all four pins carry the serial function.
// (RL7) Each pin may become general I/O with its own direction.
// (RL8) Unselected slave ignores clock and data and shifts nothing.
`include "spi_pin_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Plain synchronous FIFO held in flip-flops
module rx_fifo #(
   parameter int WIDTH = `WORD_BITS,
   parameter int DEPTH = `RX_DEPTH
) (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [WIDTH-1:0] in_data, // Word to store
   input wire logic in_valid, // Store request
   output logic in_ready, // Room for a word
   output logic [WIDTH-1:0] out_data, // Oldest word
   output logic out_valid, // A word is waiting
   input wire logic out_ready // Consumer takes the word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic do_wr;
   logic do_rd;

   if (DEPTH < 2) begin : g_chk
      $error("rx_fifo needs a depth of at least two");
   end

   // Full and empty straight from the occupancy count
   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   // Storage, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_wr) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (do_rd) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // rx_fifo

module spi_pin_interface
   import spi_pin_pkg::*;
#(
   parameter int WIDTH = `WORD_BITS,
   parameter int DEPTH = `RX_DEPTH,
   parameter int HALF = `HALF_DIV
) (
   input wire logic clk_sys, // System clock, 200 MHz
   input wire logic reset_n, // Async reset, active low
   input wire logic master_en, // 1 master, 0 slave
   input wire logic [3:0] port_e_alt_sel, // 1 makes pin general I/O
   input wire logic [3:0] port_e_alt_dir, // 1 output when general I/O
   input wire logic [3:0] port_e_alt_out, // Level driven as general I/O
   output logic [3:0] port_e_alt_in, // Synchronised pin levels
   input wire logic [WIDTH-1:0] tx_data, // Word to send
   input wire logic tx_valid, // Word offered
   output logic tx_ready, // Word taken when valid too
   output logic [WIDTH-1:0] rx_data, // Received word
   output logic rx_valid, // Received word waiting
   input wire logic rx_ready, // Consumer takes word
   output logic busy, // Master transfer in progress
   output logic mode_fault, // Pulse: master lost select
   output logic overrun, // Pulse: slave word dropped
   input wire logic sclk_i, // Serial clock pin level
   output logic sclk_o, // Serial clock pin drive
   output logic sclk_oe, // Serial clock pin enable
   input wire logic mosi_i, // Master-out pin level
   output logic mosi_o, // Master-out pin drive
   output logic mosi_oe, // Master-out pin enable
   input wire logic miso_i, // Master-in pin level
   output logic miso_o, // Master-in pin drive
   output logic miso_oe, // Master-in pin enable
   input wire logic ss_n_i, // Select pin level, low active
   output logic ss_n_o, // Select pin drive
   output logic ss_n_oe // Select pin enable
);
   localparam int CW = (WIDTH > 1) ? $clog2(WIDTH) : 1;
   localparam int DW = $clog2(HALF + 1);
   localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);
   localparam logic [DW-1:0] HLAST = DW'(HALF - 1);

   if (HALF < `HALF_DIV_MIN || WIDTH < 2) begin : g_chk
      $error("spi_pin_interface: half period or width too small");
   end

   // Two-stage synchronisers for every pin into the system domain
   logic [3:0] pin_raw;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   assign pin_raw = {ss_n_i, miso_i, mosi_i, sclk_i};
   for (genvar k = 0; k < `PIN_COUNT; k++) begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            sync1_q[k] <= 1'b1;
            sync2_q[k] <= 1'b1;
         end else begin
            sync1_q[k] <= pin_raw[k];
            sync2_q[k] <= sync1_q[k];
         end
      end
   end

   // Control inputs captured; cleared selects give serial function
   logic [3:0] alt_sel_q;
   logic [3:0] alt_dir_q;
   logic [3:0] alt_out_q;
   logic master_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         alt_sel_q <= '0; // [RL6]
         alt_dir_q <= '0;
         alt_out_q <= '0;
         master_q <= 1'b0;
         port_e_alt_in <= '0;
      end else begin
         alt_sel_q <= port_e_alt_sel; // [RL7]
         alt_dir_q <= port_e_alt_dir; // [RL7]
         alt_out_q <= port_e_alt_out;
         master_q <= master_en;
         port_e_alt_in <= sync2_q;
      end
   end

   logic ss_s;
   logic miso_s;
   logic ss_seen;
   assign ss_s = sync2_q[`PIN_SS];
   assign miso_s = sync2_q[`PIN_MISO];
   // Select only counts while the pin carries its serial function
   assign ss_seen = !alt_sel_q[`PIN_SS] && !ss_s;

   // ---- Slave side, clocked by the serial clock pin ----
   // Select high holds the shifter in reset, so stray edges do nothing
   logic [WIDTH-1:0] tx_hold_q;
   logic [CW-1:0] s_cnt_q;
   logic [WIDTH-2:0] s_sh_q;
   logic s_miso_q;
   logic s_phase_q;
   logic [WIDTH-1:0] s_word_q;
   logic s_tgl_q;

   // Sample data in on the rising edge
   always_ff @(posedge sclk_i or posedge ss_n_i) begin
      if (ss_n_i) begin
         s_cnt_q <= '0; // [RL8]
         s_sh_q <= '0;
      end else begin
         s_sh_q <= {s_sh_q[WIDTH-3:0], mosi_i}; // [RL4]
         s_cnt_q <= (s_cnt_q == LAST) ? '0 : s_cnt_q + 1'b1;
      end
   end

   // Finished words stay here across frames for the toggle crossing
   always_ff @(posedge sclk_i or negedge reset_n) begin
      if (!reset_n) begin
         s_word_q <= '0;
         s_tgl_q <= 1'b0;
      end else if (!ss_n_i && s_cnt_q == LAST) begin
         s_word_q <= {s_sh_q, mosi_i};
         s_tgl_q <= !s_tgl_q;
      end
   end

   // Next bit leaves on the falling edge, half a cycle before sampling
   always_ff @(negedge sclk_i or posedge ss_n_i) begin
      if (ss_n_i) begin
         s_miso_q <= 1'b0;
         s_phase_q <= 1'b0;
      end else begin
         s_miso_q <= tx_hold_q[LAST - s_cnt_q];
         s_phase_q <= 1'b1;
      end
   end

   // First bit comes straight from the held word before any edge.
   // The held word only changes while unselected, so it is stable here.
   logic s_bit;
   assign s_bit = s_phase_q ? s_miso_q : tx_hold_q[WIDTH-1];

   // Slave word crossing: toggle through two flops, edge seen after
   logic tgl1_q;
   logic tgl2_q;
   logic tgl3_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tgl1_q <= 1'b0;
         tgl2_q <= 1'b0;
         tgl3_q <= 1'b0;
      end else begin
         tgl1_q <= s_tgl_q;
         tgl2_q <= tgl1_q;
         tgl3_q <= tgl2_q;
      end
   end

   // ---- Master side, serial clock derived from the system clock ----
   m_state_t m_state_q;
   logic [DW-1:0] div_q;
   logic [CW-1:0] m_cnt_q;
   logic [WIDTH-1:0] m_tx_q;
   logic [WIDTH-1:0] m_rx_q;
   logic m_sclk_q;
   logic m_push;
   logic fifo_ready;
   logic s_push;
   logic take;
   logic half_end;
   logic fault;

   assign take = tx_valid && tx_ready;
   assign half_end = (div_q == HLAST);
   // Another master pulling select low aborts the transfer
   assign fault = master_q && ss_seen; // [RL5]
   assign m_push = (m_state_q == M_RUN) && half_end && m_sclk_q &&
                   (m_cnt_q == LAST) && !fault;

   // Transfer sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         m_state_q <= M_IDLE;
         div_q <= '0;
         m_cnt_q <= '0;
         m_sclk_q <= 1'b0;
      end else begin
         case (m_state_q)
            M_IDLE: begin
               div_q <= '0;
               m_cnt_q <= '0;
               m_sclk_q <= 1'b0;
               if (take && master_q) begin
                  m_state_q <= M_RUN;
               end
            end
            M_RUN: begin
               div_q <= half_end ? '0 : div_q + 1'b1;
               if (fault || !master_q) begin
                  m_state_q <= M_IDLE;
               end else if (half_end) begin
                  m_sclk_q <= !m_sclk_q; // [RL4]
                  if (m_sclk_q) begin
                     m_cnt_q <= m_cnt_q + 1'b1;
                     if (m_cnt_q == LAST) begin
                        m_state_q <= M_IDLE;
                     end
                  end
               end
            end
            default: m_state_q <= M_IDLE;
         endcase
      end
   end

   // Shifters: out changes on falling edge, in sampled on rising edge
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         m_tx_q <= '0;
         m_rx_q <= '0;
      end else if (m_state_q == M_IDLE) begin
         if (take) begin
            m_tx_q <= tx_data; // [RL3]
         end
      end else if (half_end) begin
         if (!m_sclk_q) begin
            m_rx_q <= {m_rx_q[WIDTH-2:0], miso_s}; // [RL1]
         end else begin
            m_tx_q <= {m_tx_q[WIDTH-2:0], 1'b0}; // [RL3]
         end
      end
   end

   // Held word for the slave; reloaded only while not selected
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tx_hold_q <= '0;
      end else if (take && !master_q) begin
         tx_hold_q <= tx_data;
      end
   end

   // Word acceptance; both need free select, master also waits for idle and buffer room
   logic ready_ok;
   assign ready_ok = master_q ?
      (m_state_q == M_IDLE && !ss_seen && fifo_ready) : !ss_seen;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= ready_ok && !take;
      end
   end

   // Status pulses and busy level
   assign s_push = (tgl2_q != tgl3_q) && !master_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         mode_fault <= 1'b0;
         overrun <= 1'b0;
      end else begin
         busy <= (m_state_q == M_RUN) && !fault && master_q;
         mode_fault <= (m_state_q == M_RUN) && fault; // [RL5]
         overrun <= s_push && !fifo_ready;
      end
   end

   // Received words from either side go through the buffer.
   // At the last falling edge all eight rising-edge samples are held.
   logic [WIDTH-1:0] fifo_in;
   assign fifo_in = m_push ? m_rx_q : s_word_q; // [RL1]
   rx_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .in_data(fifo_in),
      .in_valid(m_push || s_push),
      .in_ready(fifo_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   // Serial-function drive of each pin
   logic [3:0] spi_oe;
   logic [3:0] spi_o;
   logic run;
   assign run = (m_state_q == M_RUN) && master_q;
   assign spi_oe[`PIN_SCLK] = master_q; // [RL4]
   assign spi_o[`PIN_SCLK] = run && m_sclk_q;
   assign spi_oe[`PIN_MOSI] = master_q;
   assign spi_o[`PIN_MOSI] = m_tx_q[WIDTH-1];
   // Slave drives only while selected, else the pin floats
   assign spi_oe[`PIN_MISO] = !master_q && ss_seen; // [RL1] [RL2]
   assign spi_o[`PIN_MISO] = s_bit;
   assign spi_oe[`PIN_SS] = 1'b0; // [RL5]
   assign spi_o[`PIN_SS] = 1'b1;

   // Alternate function overrides per pin with its own direction
   logic [3:0] pin_oe;
   logic [3:0] pin_o;
   assign pin_oe = (alt_sel_q & alt_dir_q) | (~alt_sel_q & spi_oe); // [RL7]
   assign pin_o = (alt_sel_q & alt_out_q) | (~alt_sel_q & spi_o);
   assign sclk_o = pin_o[`PIN_SCLK];
   assign sclk_oe = pin_oe[`PIN_SCLK];
   assign mosi_o = pin_o[`PIN_MOSI];
   assign mosi_oe = pin_oe[`PIN_MOSI];
   assign miso_o = pin_o[`PIN_MISO];
   assign miso_oe = pin_oe[`PIN_MISO];
   assign ss_n_o = pin_o[`PIN_SS];
   assign ss_n_oe = pin_oe[`PIN_SS];
endmodule // spi_pin_interface
`default_nettype wire

/* bench/spi_pin_asserts.sv */
// Port-level checks for the serial pin block
`timescale 1ns/1ps
`default_nettype none
module spi_pin_asserts #(
   parameter int HALF = 4
) (
   input wire logic clk_sys, // Clock
   input wire logic reset_n, // Reset
   input wire logic master_en, // Role
   input wire logic [3:0] port_e_alt_sel, // Pin mux
   input wire logic [3:0] port_e_alt_dir, // Pin dir
   input wire logic busy, // Master run
   input wire logic mode_fault, // Fault pulse
   input wire logic overrun, // Drop pulse
   input wire logic rx_valid, // Word waiting
   input wire logic sclk_o, // Clock drive
   input wire logic sclk_oe, // Clock enable
   input wire logic mosi_o, // Data drive
   input wire logic mosi_oe, // Data enable
   input wire logic miso_oe, // Data enable
   input wire logic ss_n_i, // Select level
   input wire logic ss_n_oe // Select enable
);
   logic mst;
   logic slv;
   // Roles count only with every pin in serial use
   assign mst = master_en && port_e_alt_sel == 4'h0;
   assign slv = !master_en && port_e_alt_sel == 4'h0;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Four cycles cover the role register and the select sync
   sequence s_mst; mst [*4]; endsequence
   sequence s_sel; (slv && !ss_n_i) [*4]; endsequence
   sequence s_idle; (slv && ss_n_i) [*8]; endsequence
   property p_miso_m; s_mst |-> !miso_oe; endproperty
   property p_miso_s; s_sel |-> miso_oe; endproperty
   property p_miso_rel; s_idle |-> !miso_oe; endproperty
   property p_sclk_m; s_mst |-> sclk_oe; endproperty
   property p_mosi;
      busy && $rose(sclk_o) |-> mosi_o == $past(mosi_o, HALF);
   endproperty
   property p_sclk_hi; busy && $rose(sclk_o) |-> ##HALF !sclk_o; endproperty
   property p_fault;
      mst && busy && $fell(ss_n_i) |-> ##[1:5] mode_fault;
   endproperty
   property p_unsel; s_idle |-> !$rose(rx_valid) && !overrun; endproperty
   property p_rst;
      $rose(reset_n) |-> !mosi_oe && !miso_oe && !ss_n_oe;
   endproperty
   property p_gpio;
      (port_e_alt_sel == 4'hF && $stable(port_e_alt_dir)) [*3]
         |-> {ss_n_oe, miso_oe, mosi_oe, sclk_oe} == port_e_alt_dir;
   endproperty
   a_miso_m: assert property (p_miso_m)
      else $error("data-in pin driven as master");
   a_miso_s: assert property (p_miso_s)
      else $error("data-in pin not driven as selected slave");
   a_miso_rel: assert property (p_miso_rel)
      else $error("data-in pin held by unselected slave");
   a_sclk_m: assert property (p_sclk_m)
      else $error("serial clock not driven as master");
   a_mosi: assert property (p_mosi)
      else $error("data-out bit moved before its sampling edge");
   a_sclk_hi: assert property (p_sclk_hi)
      else $error("serial clock high phase length wrong");
   a_fault: assert property (p_fault)
      else $error("no fault pulse on select loss");
   a_unsel: assert property (p_unsel)
      else $error("unselected slave took data");
   a_rst: assert property (p_rst)
      else $error("pin driven straight after reset");
   a_gpio: assert property (p_gpio)
      else $error("general pin enable differs from direction");
endmodule // spi_pin_asserts
`default_nettype wire

/* bench/spi_peer.sv */
// Far-side serial device, master or slave role
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
   input wire logic sclk_w, // Clock line
   input wire logic mosi_w, // Data-out line
   input wire logic miso_w, // Data-in line
   output logic sclk_p, // Our clock
   output logic mosi_p, // Our data
   output logic mosi_pe, // Data enable
   output logic miso_p, // Returned data
   output logic miso_pe, // Return enable
   output logic ss_n_p // Our select
);
   logic [7:0] s_byte;
   logic [7:0] got;
   logic [7:0] rx_m;
   int bit_i;
   initial begin
      sclk_p = 1'b0;
      mosi_p = 1'b0;
      mosi_pe = 1'b0;
      miso_pe = 1'b0;
      ss_n_p = 1'b1;
      s_byte = 8'h00;
      bit_i = 0;
   end
   // Slave role: sample on rise, next bit after each fall
   always @(posedge sclk_w) if (miso_pe) got <= {got[6:0], mosi_w};
   always @(negedge sclk_w) if (miso_pe) bit_i <= bit_i + 1;
   assign miso_p = s_byte[7 - bit_i % 8];
   task automatic slave(input logic [7:0] b);
      s_byte = b;
      bit_i = 0;
      miso_pe = 1'b1;
   endtask
   // Select line doubles as the other master's claim
   task automatic set_ss(input logic v);
      ss_n_p = v;
   endtask
   // Master role: 6 ns clock only inside frames, bit set half early
   task automatic frame(input logic [7:0] b, input int n, input logic sel);
      int i;
      miso_pe = 1'b0;
      #1.3 ss_n_p = !sel;
      mosi_pe = 1'b1;
      #20;
      for (i = 8 * n - 1; i >= 0; i--) begin
         mosi_p = b[i % 8];
         #3 sclk_p = 1'b1;
         rx_m = {rx_m[6:0], miso_w};
         #3 sclk_p = 1'b0;
      end
      #20 ss_n_p = 1'b1;
      mosi_pe = 1'b0;
   endtask
endmodule // spi_peer
`default_nettype wire

/* bench/tb_top.sv */
// Bench for the serial pin block against a far-side peer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int HALF = 4;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic master_en = 1'b1;
   logic [3:0] port_e_alt_sel = 4'h0;
   logic [3:0] port_e_alt_dir = 4'h0;
   logic [3:0] port_e_alt_out = 4'h0;
   logic [3:0] port_e_alt_in;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic [7:0] rx_data;
   logic tx_ready, rx_valid, busy, mode_fault, overrun;
   logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
   logic sclk_p, mosi_p, mosi_pe, miso_p, miso_pe, ss_n_p;
   wire sclk_w, mosi_w, miso_w, ss_w;
   logic tog = 1'b0;
   logic [7:0] flt_n = 8'h00;
   logic [7:0] ovr_n = 8'h00;
   int fails = 0;
   int cmp_count = 0;
   always #2.5 clk_sys = ~clk_sys;
   // Undriven data lines wander so a stale level never passes
   always @(posedge clk_sys) tog <= ~tog;
   assign sclk_w = sclk_oe ? sclk_o : sclk_p;
   assign mosi_w = mosi_oe ? mosi_o : mosi_pe ? mosi_p : tog;
   assign miso_w = miso_oe ? miso_o : miso_pe ? miso_p : tog;
   assign ss_w = ss_n_oe ? ss_n_o : ss_n_p;
   // Pulse counters, since the pulses last one cycle
   always @(posedge clk_sys) if (mode_fault === 1'b1) flt_n <= flt_n + 8'h01;
   always @(posedge clk_sys) if (overrun === 1'b1) ovr_n <= ovr_n + 8'h01;
   spi_pin_interface #(.HALF(HALF)) u_dut (
      .clk_sys, .reset_n, .master_en, .port_e_alt_sel, .port_e_alt_dir,
      .port_e_alt_out, .port_e_alt_in, .tx_data, .tx_valid, .tx_ready,
      .rx_data, .rx_valid, .rx_ready, .busy, .mode_fault, .overrun,
      .sclk_i(sclk_w), .sclk_o, .sclk_oe, .mosi_i(mosi_w), .mosi_o,
      .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i(ss_w),
      .ss_n_o, .ss_n_oe
   );
   spi_peer u_peer (
      .sclk_w, .mosi_w, .miso_w, .sclk_p, .mosi_p, .mosi_pe, .miso_p,
      .miso_pe, .ss_n_p
   );
   task automatic close_out;
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded wait on a flag; a lapse ends the run
   task automatic wait_on(input int k);
      int n;
      for (n = 0; n < 3000; n++) begin
         @(posedge clk_sys);
         #1;
         if (k == 0 && tx_ready === 1'b1) break;
         if (k == 1 && rx_valid === 1'b1) break;
      end
      if (n == 3000) begin
         chk("wait", 8'h01, 8'h00);
         close_out();
      end
   endtask
   // The word goes at the edge where ready was already high
   task automatic send(input logic [7:0] b);
      int n;
      @(posedge clk_sys);
      tx_data <= b;
      tx_valid <= 1'b1;
      for (n = 0; n < 3000; n++) begin
         @(posedge clk_sys);
         if (tx_ready === 1'b1) break;
      end
      tx_valid <= 1'b0;
      if (n == 3000) begin
         chk("wait", 8'h01, 8'h00);
         close_out();
      end
   endtask
   task automatic pop(input logic [7:0] b);
      wait_on(1);
      chk("rx_data", b, rx_data);
      @(posedge clk_sys);
      rx_ready <= 1'b1;
      @(posedge clk_sys);
      rx_ready <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_reset;
      settle(5);
      chk("oe_rst", 8'h00, {4'h0, ss_n_oe, miso_oe, mosi_oe, sclk_oe});
      @(posedge clk_sys);
      reset_n <= 1'b1;
      settle(3);
      chk("oe_run", 8'h01, {5'h0, ss_n_oe, miso_oe, sclk_oe});
   endtask
   // Two words back to back; the peer's first byte is seen mid-run
   task automatic t_master;
      u_peer.slave(8'hA5);
      send(8'h3C);
      send(8'hC3);
      chk("peer_rx", 8'h3C, u_peer.got);
      pop(8'hA5);
      pop(8'hA5);
      chk("peer_rx", 8'hC3, u_peer.got);
      chk("miso_oe", 8'h00, {7'h0, miso_oe});
   endtask
   task automatic t_fault;
      send(8'h77);
      settle(6);
      u_peer.set_ss(1'b0);
      settle(12);
      chk("fault", 8'h01, flt_n);
      chk("busy", 8'h00, {6'h0, busy, tx_ready});
      u_peer.set_ss(1'b1);
      settle(8);
      chk("aborted", 8'h00, {7'h0, rx_valid});
   endtask
   // Outputs read back through the resolved pins
   task automatic gp(input logic [3:0] d, input logic [3:0] o);
      @(posedge clk_sys);
      port_e_alt_sel <= 4'hF;
      port_e_alt_dir <= d;
      port_e_alt_out <= o;
      settle(5);
      chk("gpio_oe", {4'h0, d}, {4'h0, ss_n_oe, miso_oe, mosi_oe, sclk_oe});
      chk("gpio_in", {4'h0, o & d}, {4'h0, port_e_alt_in & d});
   endtask
   task automatic t_gpio;
      gp(4'h5, 4'h4);
      chk("ss_in", 8'h01, {7'h0, port_e_alt_in[3]});
      gp(4'hA, 4'h8);
   endtask
   // Slave word, then a full buffer while the consumer stalls
   task automatic t_slave;
      int i;
      @(posedge clk_sys);
      port_e_alt_sel <= 4'h0;
      master_en <= 1'b0;
      settle(4);
      send(8'h96);
      u_peer.frame(8'h5A, 1, 1'b1);
      chk("slave_out", 8'h96, u_peer.rx_m);
      pop(8'h5A);
      settle(4);
      chk("miso_rel", 8'h00, {7'h0, miso_oe});
      u_peer.frame(8'h11, 33, 1'b1);
      settle(8);
      chk("overrun", 8'h01, ovr_n);
      chk("resent", 8'h96, u_peer.rx_m);
      for (i = 0; i < 32; i++) pop(8'h11);
      settle(1);
      chk("empty", 8'h00, {7'h0, rx_valid});
   endtask
   task automatic t_unsel;
      u_peer.frame(8'hFF, 2, 1'b0);
      settle(6);
      chk("unsel_rx", 8'h00, {7'h0, rx_valid});
      chk("unsel_oe", 8'h00, {7'h0, miso_oe});
   endtask
   initial begin
      t_reset();
      t_master();
      t_fault();
      t_gpio();
      t_slave();
      t_unsel();
      close_out();
   end
endmodule // tb_top
bind spi_pin_interface spi_pin_asserts #(.HALF(HALF)) u_chk (
   .clk_sys, .reset_n, .master_en, .port_e_alt_sel, .port_e_alt_dir,
   .busy, .mode_fault, .overrun, .rx_valid, .sclk_o, .sclk_oe, .mosi_o,
   .mosi_oe, .miso_oe, .ss_n_i, .ss_n_oe
);
`default_nettype wire
